/* verilog/led_register_pkg.sv */
// Package for the LED driver register array: field layout of the serial
// command and response words, register map tables and frame constants.
// Assumes a single clock domain and a 6-bit register address space.
package led_register_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Address space and word layout
	localparam int          ADDR_WIDTH  = 6;
	localparam int          DATA_WIDTH  = 8;
	localparam int          FRAME_WIDTH = 16;
	localparam int          NUM_ADDR    = 64;
	localparam logic [5:0]  ADDR_FIRST  = 6'h00;
	localparam logic [5:0]  ADDR_LAST   = 6'h3f;

	// Command word bit positions, write/read bit first, data last
	localparam int          CMD_BIT       = 15;
	localparam int          ADDR_MSB      = 14;
	localparam int          ADDR_LSB      = 9;
	localparam int          PARITY_BIT    = 8;
	localparam int          DATA_MSB      = 7;
	localparam logic        CMD_WRITE     = 1'b1;
	localparam logic        CMD_READ      = 1'b0;
	localparam logic        PARITY_ODD    = 1'b1;

	// Response words
	localparam logic [15:0] WRITE_ERROR_FRAME  = 16'h8000;
	localparam logic [4:0]  READ_FIXED_FIELD   = 5'h18;
	localparam logic [7:0]  ZERO_BYTE          = 8'h00;

	// Registers with special handling
	localparam logic [5:0]  ADDR_SYSTEM_CONFIG_1 = 6'h00;
	localparam logic [5:0]  ADDR_DEVICE_STATUS   = 6'h05;
	localparam int          FAULT_PIN_RESET_BIT  = 7;
	localparam int          THERMAL_WARN_BIT     = 3;
	localparam int          POWER_CYCLED_BIT     = 2;

	typedef enum logic [1:0] {
		KIND_NONE,
		KIND_RW,
		KIND_RO
	} reg_kind_type;

	typedef logic [5:0] addr_type;
	typedef logic [7:0] byte_type;

	////////////////////////////////////////////////////////////////////////////////
	// Register map: kind of each address
	localparam reg_kind_type KIND_TABLE [NUM_ADDR] = '{
		6'h00: KIND_RW, 6'h01: KIND_RW, 6'h02: KIND_RW, 6'h03: KIND_RO,
		6'h04: KIND_RO, 6'h05: KIND_RO, 6'h06: KIND_RW, 6'h07: KIND_RW,
		6'h08: KIND_RW, 6'h09: KIND_RW, 6'h0a: KIND_RW, 6'h0b: KIND_RW,
		6'h0c: KIND_RW, 6'h0d: KIND_RW, 6'h0e: KIND_RW, 6'h0f: KIND_RW,
		6'h10: KIND_RW, 6'h11: KIND_RW, 6'h12: KIND_RW, 6'h13: KIND_RO,
		6'h14: KIND_RO, 6'h15: KIND_RO, 6'h16: KIND_RO, 6'h17: KIND_RO,
		6'h18: KIND_RO, 6'h19: KIND_RO, 6'h1a: KIND_RO, 6'h1b: KIND_RO,
		6'h1c: KIND_RO, 6'h1d: KIND_RO, 6'h1e: KIND_RW, 6'h1f: KIND_RW,
		6'h20: KIND_RO, 6'h21: KIND_RO, 6'h22: KIND_RO, 6'h23: KIND_RO,
		6'h24: KIND_RW, 6'h25: KIND_RW, 6'h26: KIND_RW, 6'h27: KIND_RW,
		6'h28: KIND_RW, 6'h29: KIND_RW, 6'h2a: KIND_RW, 6'h2b: KIND_RW,
		6'h2c: KIND_RW, 6'h2d: KIND_RW,
		default: KIND_NONE
	};

	// Stored bits of each writable register; reserved bits are not stored
	localparam byte_type STORE_MASK_TABLE [NUM_ADDR] = '{
		6'h00: 8'h7f, 6'h01: 8'hff, 6'h02: 8'h0f, 6'h06: 8'hff,
		6'h07: 8'h03, 6'h08: 8'h03, 6'h09: 8'hff, 6'h0a: 8'h03,
		6'h0b: 8'hff, 6'h0c: 8'h07, 6'h0d: 8'hff, 6'h0e: 8'h03,
		6'h0f: 8'hff, 6'h10: 8'h03, 6'h11: 8'h3f, 6'h12: 8'h3f,
		6'h1e: 8'hff, 6'h1f: 8'hff, 6'h24: 8'h03, 6'h25: 8'hff,
		6'h26: 8'h03, 6'h27: 8'hff, 6'h28: 8'hff, 6'h29: 8'h03,
		6'h2a: 8'hff, 6'h2b: 8'h03, 6'h2c: 8'h3f, 6'h2d: 8'h3f,
		default: 8'h00
	};

	// Default contents loaded at reset
	localparam byte_type RESET_TABLE [NUM_ADDR] = '{
		6'h00: 8'h10, 6'h02: 8'h08, 6'h06: 8'h8a, 6'h0c: 8'h04,
		6'h11: 8'h07, 6'h12: 8'h07, 6'h2c: 8'h07, 6'h2d: 8'h07,
		default: 8'h00
	};

endpackage

/* verilog/serial_frame_shifter.sv */
// Serial frame shifter: 16-bit receive and transmit shift registers for
// the four-wire link, with frame length checking.
// Assumes link pins already synchronous to clk_in, clock idles low.
`timescale 1ns/1ps
`default_nettype none
module serial_frame_shifter
	import led_register_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic        chip_select_low_in,
	input  wire logic        sck_in,
	input  wire logic        mosi_in,
	input  wire logic [15:0] load_word_in,
	output logic             frame_done_out,
	output logic             length_error_out,
	output logic [15:0]      frame_word_out,
	output logic             miso_oe_out
);

	typedef struct packed {
		logic        cs_prev;
		logic        sck_prev;
		logic        active;
		logic        any_edge;
		logic [3:0]  count;
		logic [15:0] rx;
		logic [15:0] tx;
		logic        done;
		logic        length_error;
	} shifter_state_type;

	shifter_state_type state;
	shifter_state_type next_state;

	////////////////////////////////////////////////////////////////////////////////
	// Edge detection, shifting and frame end
	always_comb begin
		next_state          = state;
		next_state.cs_prev  = chip_select_low_in;
		next_state.sck_prev = sck_in;
		next_state.done     = 1'b0;
		if (state.cs_prev && !chip_select_low_in) begin
			// Frame opens: first outgoing bit appears at once
			next_state.active   = 1'b1;
			next_state.any_edge = 1'b0;
			next_state.count    = '0;
			next_state.tx       = load_word_in;
		end else if (state.active && !chip_select_low_in) begin
			if (!state.sck_prev && sck_in) begin
				next_state.rx       = {state.rx[14:0], mosi_in};
				next_state.count    = state.count + 4'h1;
				next_state.any_edge = 1'b1;
			end else if (state.sck_prev && !sck_in) begin
				// Later bits pass through, as in a daisy chain
				next_state.tx = {state.tx[14:0], state.rx[0]};
			end
		end else if (state.active && chip_select_low_in) begin
			// Frame closes: only a nonzero multiple of 16 clocks is valid
			next_state.active       = 1'b0;
			next_state.done         = 1'b1;
			next_state.length_error = !state.any_edge || (state.count != 4'h0);
		end
	end

	// State register
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			state         <= '0;
			state.cs_prev <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	assign frame_done_out   = state.done;
	assign length_error_out = state.length_error;
	assign frame_word_out   = state.rx;
	assign miso_oe_out      = state.active && !state.tx[FRAME_WIDTH-1]; // Open drain pulls low only

endmodule
`default_nettype wire

/* verilog/dual_led_driver_register_array.sv */
// Register array of a dual channel LED driver, reached over a four-wire
// serial link, with command decode, write apply and response building.
// Assumes status values come from the analog side, synchronous to clk_in.
//
// Functional notes
// - 64 byte-wide addresses, 0x00 to 0x3f.
// - Reset loads every register's default value.
// - Reading unassigned addresses returns zero.
// - Registers read and write unless restricted.
// - Status registers show live internal conditions.
// - Command: write bit, address, parity, data.
// - Write applied at frame end, only error free.
// - Erroneous write leaves register unchanged.
// - Next response returns written register's readback.
`timescale 1ns/1ps
`default_nettype none
module dual_led_driver_register_array
	import led_register_pkg::*;
(
	input  wire logic                  clk_in,
	input  wire logic                  reset_in,
	input  wire logic                  chip_select_low_in,
	input  wire logic                  sck_in,
	input  wire logic                  mosi_in,
	output logic                       miso_out,
	output logic                       miso_oe_out,
	input  wire logic [63:0][7:0]      status_in,
	output logic [63:0][7:0]           register_values_out,
	output logic                       fault_pin_reset_out,
	output logic                       status_read_out,
	output logic [5:0]                 status_read_addr_out,
	output logic                       link_error_flag_out
);

	typedef struct packed {
		logic [63:0][7:0] regs;
		logic [15:0]      response;
		logic             fault_pin_reset;
		logic             status_read;
		logic [5:0]       status_read_addr;
		logic             link_error_flag;
		logic             miso_level;
	} bank_state_type;

	bank_state_type state;
	bank_state_type next_state;

	logic        frame_done;
	logic        length_error;
	logic [15:0] frame_word;

	////////////////////////////////////////////////////////////////////////////////
	// Register map decode helpers

	// Value seen by a read of one address
	function automatic byte_type read_value(input logic [63:0][7:0] regs, input addr_type addr,
		input logic [63:0][7:0] status);
		byte_type value;
		value = ZERO_BYTE;
		case (KIND_TABLE[addr])
			KIND_RW: value = regs[addr] & STORE_MASK_TABLE[addr];
			KIND_RO: value = status[addr];
			KIND_NONE: value = ZERO_BYTE;
			default: value = ZERO_BYTE;
		endcase
		return value;
	endfunction

	// True for an address that software may write
	function automatic logic is_writable(input addr_type addr);
		return KIND_TABLE[addr] == KIND_RW;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Serial shifter
	serial_frame_shifter shifter (
		.clk_in             (clk_in),
		.reset_in           (reset_in),
		.chip_select_low_in (chip_select_low_in),
		.sck_in             (sck_in),
		.mosi_in            (mosi_in),
		.load_word_in       (state.response),
		.frame_done_out     (frame_done),
		.length_error_out   (length_error),
		.frame_word_out     (frame_word),
		.miso_oe_out        (miso_oe_out)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Command decode and response building
	always_comb begin
		logic     is_write;
		addr_type addr;
		byte_type data;
		logic     parity_bad;
		logic     frame_error;
		byte_type readback;
		logic     tw_bit;
		logic     pc_bit;
		is_write    = frame_word[CMD_BIT];
		addr        = frame_word[ADDR_MSB:ADDR_LSB];
		data        = frame_word[DATA_MSB:0];
		parity_bad  = (^frame_word) != PARITY_ODD;
		frame_error = length_error || parity_bad || (!is_write && (data != ZERO_BYTE));
		readback    = ZERO_BYTE;
		tw_bit      = status_in[ADDR_DEVICE_STATUS][THERMAL_WARN_BIT];
		pc_bit      = status_in[ADDR_DEVICE_STATUS][POWER_CYCLED_BIT];
		next_state                 = state;
		next_state.fault_pin_reset = 1'b0;
		next_state.status_read     = 1'b0;
		next_state.miso_level      = 1'b0;
		if (frame_done) begin
			next_state.link_error_flag = frame_error;
			if (is_write == CMD_WRITE) begin
				if (frame_error) begin
					// Nothing is stored; the error frame answers next
					next_state.response = WRITE_ERROR_FRAME;
				end else begin
					if (is_writable(addr)) begin
						// Reserved bits are dropped, never stored
						next_state.regs[addr] = data & STORE_MASK_TABLE[addr];
					end
					if ((addr == ADDR_SYSTEM_CONFIG_1) && data[FAULT_PIN_RESET_BIT]) begin
						next_state.fault_pin_reset = 1'b1;
					end
					readback            = read_value(next_state.regs, addr, status_in);
					next_state.response = {1'b0, CMD_WRITE, addr, readback};
				end
			end else begin
				// Read data is captured at frame end and sent next frame
				readback            = read_value(state.regs, addr, status_in);
				next_state.response = {frame_error, READ_FIXED_FIELD, pc_bit, tw_bit, readback};
				if (!frame_error && (KIND_TABLE[addr] == KIND_RO)) begin
					next_state.status_read      = 1'b1;
					next_state.status_read_addr = addr;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register; defaults loaded before any frame is served
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			state          <= '0;
			state.response <= WRITE_ERROR_FRAME;
			for (int i = 0; i < NUM_ADDR; i++) begin
				state.regs[i] <= RESET_TABLE[i];
			end
		end else begin
			state <= next_state;
		end
	end

	// Outputs
	assign miso_out             = state.miso_level;
	assign register_values_out  = state.regs;
	assign fault_pin_reset_out  = state.fault_pin_reset;
	assign status_read_out      = state.status_read;
	assign status_read_addr_out = state.status_read_addr;
	assign link_error_flag_out  = state.link_error_flag;

endmodule
`default_nettype wire

/* test/led_array_checker_assertions.sv */
// Port checker for the LED driver register array.
// Assumes one clk_in domain and the active high reset_in.
`timescale 1ns/1ps
`default_nettype none
module led_array_checker
	import led_register_pkg::*;
(
	input  wire logic             clk_in,
	input  wire logic             reset_in,
	input  wire logic             chip_select_low_in,
	input  wire logic             miso_oe_out,
	input  wire logic [63:0][7:0] register_values_out,
	input  wire logic             fault_pin_reset_out,
	input  wire logic             status_read_out,
	input  wire logic [5:0]       status_read_addr_out,
	input  wire logic             link_error_flag_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	////////////////////////////////////////////////////////////////////////////////
	// Link idle for three samples
	sequence idle_s;
		chip_select_low_in [*3];
	endsequence
	// Register, flag and MISO release checks
	reset_load_a: assert property ($fell(reset_in) |->
		register_values_out[0] == 8'h10 && register_values_out[6] == 8'h8a) else $error("defaults not loaded");
	write_at_end_a: assert property ($changed(register_values_out) |-> chip_select_low_in)
		else $error("register changed inside a frame");
	reserved_zero_a: assert property (register_values_out[0][7] == 1'b0 &&
		register_values_out[2][7:4] == 4'h0 && register_values_out[7][7:2] == 6'h00) else $error("reserved bit held");
	unassigned_zero_a: assert property (register_values_out[63:46] == '0 &&
		register_values_out[3] == 8'h00) else $error("unassigned byte not zero");
	fault_pulse_a: assert property (fault_pin_reset_out |-> chip_select_low_in ##1 !fault_pin_reset_out)
		else $error("fault reset pulse wrong");
	status_pulse_a: assert property (status_read_out |-> chip_select_low_in ##1 !status_read_out)
		else $error("status read pulse wrong");
	status_addr_a: assert property ($changed(status_read_addr_out) |-> status_read_out)
		else $error("status address moved without read");
	error_at_end_a: assert property ($changed(link_error_flag_out) |-> chip_select_low_in)
		else $error("error flag moved inside a frame");
	idle_release_a: assert property (idle_s |-> !miso_oe_out)
		else $error("miso driven while idle");
endmodule
`default_nettype wire
bind dual_led_driver_register_array led_array_checker chk_u (.clk_in(clk_in), .reset_in(reset_in),
	.chip_select_low_in(chip_select_low_in), .miso_oe_out(miso_oe_out), .register_values_out(register_values_out),
	.fault_pin_reset_out(fault_pin_reset_out), .status_read_out(status_read_out),
	.status_read_addr_out(status_read_addr_out), .link_error_flag_out(link_error_flag_out));

/* test/host_link_model.sv */
// Host side of the four-wire link: sends frames, collects responses.
// Assumes a pull-up on the data return line, pulled low by the device.
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
	input  wire logic clk_in,
	input  wire logic miso_in,
	input  wire logic miso_oe_in,
	output var logic  chip_select_low_out,
	output var logic  sck_out,
	output var logic  mosi_out
);
	wire logic line;
	// Released line floats up to the pull-up level
	assign line = miso_oe_in ? miso_in : 1'b1;
	// Idle link at time zero, serial clock parked low
	initial begin
		chip_select_low_out = 1'b1;
		sck_out = 1'b0;
		mosi_out = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// One frame of n clocks, top bits of w first, two clk per phase
	task automatic frame(input int n, input logic [15:0] w, output logic [15:0] r);
		r = 16'h0000;
		@(posedge clk_in) #1 chip_select_low_out = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			mosi_out = w[i + 16 - n];
			repeat (2) @(posedge clk_in);
			#1 sck_out = 1'b1;
			r = {r[14:0], line};
			repeat (2) @(posedge clk_in);
			#1 sck_out = 1'b0;
		end
		repeat (2) @(posedge clk_in);
		#1 chip_select_low_out = 1'b1;
		mosi_out = ~mosi_out;
		repeat (6) @(posedge clk_in);
	endtask
endmodule
`default_nettype wire

/* test/test_dual_led_driver_register_array.sv */
// Bench for the LED driver register array, driven by the host model.
// Assumes the host model is the only driver of the link inputs.
`timescale 1ns/1ps
`default_nettype none
module test_dual_led_driver_register_array;
	import led_register_pkg::*;
	localparam logic [7:0] RH = 8'h62;
	logic                  clk_in = 1'b0;
	logic                  reset_in = 1'b1;
	wire logic             chip_select_low;
	wire logic             sck;
	wire logic             mosi;
	logic                  miso;
	logic                  miso_oe;
	logic [63:0][7:0]      st;
	logic [63:0][7:0]      regs;
	logic                  le;
	logic                  fpr;
	logic                  sr;
	logic [5:0]            sra;
	logic [15:0]           last;
	logic [15:0]           e;
	int                    err_count = 0;
	int                    n_tests = 0;
	int                    fpr_n = 0;
	int                    sr_n = 0;
	// Clock and instances
	initial forever #10 clk_in = ~clk_in;
	host_link_model host_u (.clk_in(clk_in), .miso_in(miso), .miso_oe_in(miso_oe),
		.chip_select_low_out(chip_select_low), .sck_out(sck), .mosi_out(mosi));
	dual_led_driver_register_array dut_u (.clk_in(clk_in), .reset_in(reset_in), .chip_select_low_in(chip_select_low),
		.sck_in(sck), .mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe), .status_in(st),
		.register_values_out(regs), .fault_pin_reset_out(fpr), .status_read_out(sr), .status_read_addr_out(sra),
		.link_error_flag_out(le));
	// Count the one-cycle pulses so that later checks can see them
	always @(posedge clk_in) begin
		if (fpr === 1'b1) fpr_n <= fpr_n + 1;
		if (sr === 1'b1) sr_n <= sr_n + 1;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Command word with odd parity over all sixteen bits
	function automatic logic [15:0] cw(input logic w, input logic [5:0] a, input logic [7:0] d);
		return {w, a, ~^{w, a, d}, d};
	endfunction
	task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
		n_tests++;
		if (got !== ex) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic go(input int n, input logic [15:0] w, input logic [15:0] ex);
		host_u.frame(n, w, last);
		chk("response", ex, last);
	endtask
	task automatic report_and_stop;
		$display("mismatches %0d comparisons %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Hang guard
	initial begin
		#1ms err_count++;
		report_and_stop();
	end
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		for (int i = 0; i < 64; i++) st[i] = 8'hc0 | 8'(i);
		repeat (12) @(posedge clk_in);
		#1 reset_in = 1'b0;
		for (int i = 0; i < 64; i++) chk("reset value", 16'(RESET_TABLE[i]), 16'(regs[i]));
		go(16, cw(1'b0, 6'h00, 8'h00), 16'h8000);
		go(16, cw(1'b0, 6'h3f, 8'h00), {RH, 8'h10});
		e = {RH, 8'h00};
		for (int a = 0; a < 64; a++) if (KIND_TABLE[a] == KIND_RW) begin
			// Reserved bits go out as zero; bit 7 of address 0 is a command bit
			go(16, cw(1'b1, 6'(a), (a == 0) ? 8'hff : STORE_MASK_TABLE[a]), e);
			e = {2'b01, 6'(a), STORE_MASK_TABLE[a]};
			chk("stored", 16'(STORE_MASK_TABLE[a]), 16'(regs[a]));
		end
		go(16, cw(1'b0, 6'h13, 8'h00), e);
		go(16, cw(1'b1, 6'h06, 8'h55) ^ 16'h0100, {RH, 8'hd3});
		chk("error flag", 16'h0001, 16'(le));
		go(16, cw(1'b0, 6'h06, 8'h00), 16'h8000);
		// Only the top eight response bits are clocked out in a short frame
		go(8, cw(1'b0, 6'h06, 8'h00), 16'(RH));
		chk("error flag", 16'h0001, 16'(le));
		host_u.frame(16, cw(1'b0, 6'h05, 8'h00), last);
		chk("error response", 16'h00e2, 16'(last[15:8]));
		go(16, cw(1'b0, 6'h2e, 8'h00), {RH, 8'hc5});
		chk("error flag", 16'h0000, 16'(le));
		go(16, cw(1'b1, 6'h1e, 8'ha5), {RH, 8'h00});
		go(16, cw(1'b0, 6'h1e, 8'h00), {2'b01, 6'h1e, 8'ha5});
		// Read of a status address with nonzero data is an error and no status read
		go(16, cw(1'b0, 6'h04, 8'h01), {RH, 8'ha5});
		chk("error flag", 16'h0001, 16'(le));
		chk("fault pulses", 16'h0001, 16'(fpr_n));
		chk("status reads", 16'h0002, 16'(sr_n));
		chk("status address", 16'h0005, 16'(sra));
		#1 reset_in = 1'b1;
		repeat (2) @(posedge clk_in);
		#1 reset_in = 1'b0;
		chk("second reset", 16'h008a, 16'(regs[6]));
		go(16, cw(1'b0, 6'h00, 8'h00), 16'h8000);
		report_and_stop();
	end
endmodule
`default_nettype wire
